// *** pkg/oir_consts.svh ***
/*
 * register offsets, field positions, reset values and pwm timing for the
 * output intensity register bank.
 * assumes it is included by bare name from packages and design files.
 */
`ifndef OIR_CONSTS_SVH
`define OIR_CONSTS_SVH

// register addresses on the internal register port
`define OIR_ADDR_MASTER_P8 8'h0e
`define OIR_ADDR_DUTY_10 8'h10
`define OIR_ADDR_DUTY_32 8'h11
`define OIR_ADDR_DUTY_54 8'h12
`define OIR_ADDR_DUTY_76 8'h13

// nibble fields within each byte
`define OIR_LO_NIB_MSB 3
`define OIR_LO_NIB_LSB 0
`define OIR_HI_NIB_MSB 7
`define OIR_HI_NIB_LSB 4

// reset values
`define OIR_DUTY_RESET 8'h00
`define OIR_MASTER_RESET 8'h00
`define OIR_UNMAPPED_READ 8'h00

// nibble value meaning static, unmodulated output
`define OIR_NIB_STATIC 4'hf
// master value meaning oscillator stopped
`define OIR_MASTER_OFF 4'h0

// pwm timing: one pwm slot every OIR_SLOT_DIV+1 (16) clocks of 40 ns
`define OIR_CLK_NS 40
`define OIR_SLOT_NS 640
`define OIR_SLOT_DIV 4'((`OIR_SLOT_NS + `OIR_CLK_NS - 1) / `OIR_CLK_NS - 1)
// fine counter runs 0..14 (master fifteenths), coarse runs 0..15
`define OIR_FINE_LAST 4'he
`define OIR_COARSE_LAST 4'hf

`endif

// *** pkg/oir_pkg.sv ***
/*
 * types for the output intensity register bank.
 * assumes oir_consts.svh is on the include path.
 */
`include "oir_consts.svh"

package oir_pkg;

   // register and pwm state of the bank
   typedef struct packed {
      logic [3:0][7:0] duty;
      logic [7:0] master_p8;
      logic [3:0] div;
      logic [3:0] fine;
      logic [3:0] coarse;
      logic [7:0] rdata;
      logic [8:0] sink;
   } oir_state_s;

   // register access request from the serial interface
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } oir_req_s;

endpackage

// *** core/oir_duty_cell.sv ***
/*
 * per-output duty decision: whether one led port sinks in the current slot.
 * assumes counters come from the bank's pwm timebase on the same clock.
 */
`include "oir_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module oir_duty_cell (
   input wire logic [3:0] nib_i,
   input wire logic [3:0] master_i,
   input wire logic [3:0] fine_i,
   input wire logic [3:0] coarse_i,
   output logic on_o
);

   always_comb
   begin
      if (nib_i == `OIR_NIB_STATIC)
      begin
         on_o = 1'b1;
      end
      else if (master_i == `OIR_MASTER_OFF)
      begin
         on_o = 1'b0;
      end
      else
      begin
         on_o = (coarse_i <= nib_i) && (fine_i < master_i);
      end
   end

endmodule // oir_duty_cell

`default_nettype wire

// *** core/oir_top.sv ***
/*
 * output intensity register bank with master and per-port pwm for nine
 * open-drain led ports.
 * assumes a serial interface on the same clock issues single-cycle
 * register writes and reads; pads resolve the open-drain outputs.
 */
`include "oir_consts.svh"
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - address 0x10 holds port 0 duty in bits 3..0, port 1 in 7..4.
// - address 0x11 holds port 2 duty low nibble, port 3 high nibble.
// - address 0x12 holds port 4 duty low nibble, port 5 high nibble.
// - address 0x13 holds port 6 duty low nibble, port 7 high nibble.
// - duty registers are writable and read back the last byte written.
// - nibble n below 15 gives pwm duty of (n+1)/16 scaled by master/15.
// - nibble 15 holds the port at a steady level, no pwm.
// - address 0x0e low nibble is port 8 duty, high nibble is master.
// - master zero stops the oscillator; all ports static.
module oir_top (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic [8:0] led_port_o,
   output logic [8:0] led_port_oe_o
);

   oir_pkg::oir_state_s s_q;
   oir_pkg::oir_state_s s_d;
   oir_pkg::oir_req_s req;
   logic [8:0][3:0] nib;
   logic [3:0] master;
   logic [8:0] on;
   logic osc_run;
   logic slot_tick;

   assign req = '{wr: wr_en_i, rd: rd_en_i, addr: addr_i, wdata: wdata_i};

   // returns the duty register index for an address, or 3'h4 for any other address (0x0e included)
   function automatic logic [2:0] duty_index(input logic [7:0] a);
      case (a)
         `OIR_ADDR_DUTY_10: duty_index = 3'h0;
         `OIR_ADDR_DUTY_32: duty_index = 3'h1;
         `OIR_ADDR_DUTY_54: duty_index = 3'h2;
         `OIR_ADDR_DUTY_76: duty_index = 3'h3;
         default: duty_index = 3'h4;
      endcase
   endfunction

   always_comb
   begin
      for (int k = 0; k < 4; k++)
      begin
         nib[2*k] = s_q.duty[k][`OIR_LO_NIB_MSB:`OIR_LO_NIB_LSB];
         nib[2*k+1] = s_q.duty[k][`OIR_HI_NIB_MSB:`OIR_HI_NIB_LSB];
      end
      nib[8] = s_q.master_p8[`OIR_LO_NIB_MSB:`OIR_LO_NIB_LSB];
   end
   assign master = s_q.master_p8[`OIR_HI_NIB_MSB:`OIR_HI_NIB_LSB];

   assign osc_run = (master != `OIR_MASTER_OFF);
   assign slot_tick = osc_run && (s_q.div == `OIR_SLOT_DIV);

   for (genvar g = 0; g < 9; g++)
   begin : g_cell
      oir_duty_cell u_cell (
         .nib_i(nib[g]),
         .master_i(master),
         .fine_i(s_q.fine),
         .coarse_i(s_q.coarse),
         .on_o(on[g])
      );
   end

   always_comb
   begin
      logic [2:0] idx;
      idx = duty_index(req.addr);
      s_d = s_q;
      if (req.wr)
      begin
         if (idx != 3'h4)
         begin
            s_d.duty[idx[1:0]] = req.wdata;
         end
         else if (req.addr == `OIR_ADDR_MASTER_P8)
         begin
            s_d.master_p8 = req.wdata;
         end
      end
      if (req.rd)
      begin
         if (idx != 3'h4)
         begin
            s_d.rdata = s_q.duty[idx[1:0]];
         end
         else if (req.addr == `OIR_ADDR_MASTER_P8)
         begin
            s_d.rdata = s_q.master_p8;
         end
         else
         begin
            s_d.rdata = `OIR_UNMAPPED_READ;
         end
      end
      // timebase cleared and held at zero when master is off
      if (!osc_run)
      begin
         s_d.div = 4'h0;
         s_d.fine = 4'h0;
         s_d.coarse = 4'h0;
      end
      else if (slot_tick)
      begin
         s_d.div = 4'h0;
         // fine (master) nested inside coarse (port)
         if (s_q.fine == `OIR_FINE_LAST)
         begin
            s_d.fine = 4'h0;
            s_d.coarse = s_q.coarse + 4'h1;
         end
         else
         begin
            s_d.fine = s_q.fine + 4'h1;
         end
      end
      else
      begin
         s_d.div = s_q.div + 4'h1;
      end
      s_d.sink = on;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_q.duty <= {4{`OIR_DUTY_RESET}};
         s_q.master_p8 <= `OIR_MASTER_RESET;
         s_q.div <= 4'h0;
         s_q.fine <= 4'h0;
         s_q.coarse <= 4'h0;
         s_q.rdata <= 8'h00;
         s_q.sink <= 9'h000;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;
   assign led_port_oe_o = s_q.sink;
   // open drain: the driven level is always low
   assign led_port_o = 9'h000;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence wr_to(logic [7:0] a);
      req.wr && req.addr == a;
   endsequence

   a_bank10_layout: assert property (
      wr_to(`OIR_ADDR_DUTY_10) |=> nib[0] == $past(wdata_i[3:0]) && nib[1] == $past(wdata_i[7:4]))
      else $error("port 0/1 nibbles not taken from 0x10");
   a_bank11_layout: assert property (
      wr_to(`OIR_ADDR_DUTY_32) |=> nib[2] == $past(wdata_i[3:0]) && nib[3] == $past(wdata_i[7:4]))
      else $error("port 2/3 nibbles not taken from 0x11");
   a_bank12_layout: assert property (
      wr_to(`OIR_ADDR_DUTY_54) |=> nib[4] == $past(wdata_i[3:0]) && nib[5] == $past(wdata_i[7:4]))
      else $error("port 4/5 nibbles not taken from 0x12");
   a_bank13_layout: assert property (
      wr_to(`OIR_ADDR_DUTY_76) |=> nib[6] == $past(wdata_i[3:0]) && nib[7] == $past(wdata_i[7:4]))
      else $error("port 6/7 nibbles not taken from 0x13");
   a_duty_readback: assert property (
      (wr_to(`OIR_ADDR_DUTY_54) ##1 (req.rd && !req.wr && req.addr == `OIR_ADDR_DUTY_54))
      |=> rdata_o == $past(wdata_i, 2))
      else $error("duty register read-back mismatch");
   a_port_duty: assert property (
      led_port_oe_o[0] && $past(nib[0]) != `OIR_NIB_STATIC |-> $past(s_q.coarse) <= $past(nib[0]))
      else $error("port 0 sinks outside its duty slots");
   a_static_level: assert property (
      (nib[3] == `OIR_NIB_STATIC)[*2] |-> led_port_oe_o[3])
      else $error("static port 3 not held on");
   a_port8_layout: assert property (
      wr_to(`OIR_ADDR_MASTER_P8) |=> nib[8] == $past(wdata_i[3:0]) && master == $past(wdata_i[7:4]))
      else $error("port 8 / master fields not taken from 0x0e");
   a_osc_stopped: assert property (
      (master == `OIR_MASTER_OFF)[*2] |-> s_q.fine == 4'h0 && s_q.coarse == 4'h0 && s_q.div == 4'h0)
      else $error("timebase runs with master off");
   a_master_gate: assert property (
      led_port_oe_o[0] && $past(nib[0]) != `OIR_NIB_STATIC |-> $past(s_q.fine) < $past(master))
      else $error("port 0 sinks outside master on-time");

endmodule // oir_top

`default_nettype wire

// *** tb/oir_host_model.sv ***
/*
 * register-port host standing for the serial bus master: single-cycle
 * write and read strobes launched just after a rising edge.
 * assumes the bank takes a request on the edge after it is driven.
 */
`timescale 1ns/10ps
`default_nettype none

module oir_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial
   begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end

   // released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_en_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      addr_o <= ~a;
      // read data was registered on the taking edge and stands until the next read
      @(posedge clk_i);
      d = rdata_i;
   endtask

   // write then read the same address on the very next edge
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_i);
      wr_en_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      rd_en_o <= 1'b1;
      wdata_o <= ~d;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i);
      q = rdata_i;
   endtask
endmodule // oir_host_model

`default_nettype wire

// *** tb/test_output_intensity_registers.sv ***
/*
 * self-checking bench for the output intensity register bank.
 * assumes oir_top and the host model; one 25 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module test_output_intensity_registers;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic wr_en_i;
   logic rd_en_i;
   logic [7:0] addr_i;
   logic [7:0] wdata_i;
   logic [7:0] rdata_o;
   logic [8:0] led_port_o;
   logic [8:0] led_port_oe_o;
   int failures = 0;
   int comparisons = 0;
   logic [7:0] rd_v;
   logic [11:0] on_cnt [9];
   logic [7:0] adr [5] = '{8'h0e, 8'h10, 8'h11, 8'h12, 8'h13};
   logic [7:0] val [5] = '{8'h00, 8'he3, 8'hf0, 8'h5a, 8'hc1};

   initial forever #20 clk_i = ~clk_i;

   oir_top oir_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i),
      .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .led_port_o(led_port_o), .led_port_oe_o(led_port_oe_o));

   oir_host_model oir_host_model_i (.clk_i(clk_i), .rdata_i(rdata_o),
      .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));

   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // duty nibble of port k from the written bytes
   function automatic logic [3:0] nib(input int k);
      logic [7:0] b;
      b = (k == 8) ? val[0] : val[1 + k / 2];
      return (k % 2 == 1 && k != 8) ? b[7:4] : b[3:0];
   endfunction

   initial
   begin
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      foreach (adr[i])
      begin
         oir_host_model_i.rd(adr[i], rd_v);
         chk("reset value", 12'h000, {4'h0, rd_v});
      end
      oir_host_model_i.wr(8'h14, 8'h55);
      oir_host_model_i.rd(8'h14, rd_v);
      chk("unmapped read", 12'h000, {4'h0, rd_v});
      oir_host_model_i.wr_rd(8'h12, 8'ha5, rd_v);
      chk("back-to-back readback", 12'h0a5, {4'h0, rd_v});
      foreach (adr[i])
      begin
         oir_host_model_i.wr(adr[i], val[i]);
         oir_host_model_i.rd(adr[i], rd_v);
         chk("readback", {4'h0, val[i]}, {4'h0, rd_v});
      end
      // master zero: only the all-ones port sinks, steadily
      repeat (40)
      begin
         @(negedge clk_i);
         chk("static oe", 12'h008, {3'h0, led_port_oe_o});
      end
      val[0] = 8'h70;
      oir_host_model_i.wr(adr[0], val[0]);
      repeat (3) @(posedge clk_i);
      foreach (on_cnt[k])
         on_cnt[k] = 12'h000;
      repeat (3840)
      begin
         @(negedge clk_i);
         foreach (on_cnt[k])
            on_cnt[k] += {11'h000, led_port_oe_o[k]};
      end
      foreach (on_cnt[k])
         chk($sformatf("on count port %0d", k), (nib(k) == 4'hf) ? 12'd3840 :
            12'((nib(k) + 1) * 7 * 16), on_cnt[k]);
      chk("open drain level", 12'h000, {3'h0, led_port_o});
      wrap_up();
   end
endmodule // test_output_intensity_registers

`default_nettype wire
